// ---- src/phy_gig_status_mmd_loopback_regs.sv ----
module phy_gig_status_mmd_loopback_regs #(
    parameter int SYMBOL_WIDTH = 8  // line symbol width
) (
    input wire logic clock,                               // system clock
    input wire logic rst,                                 // async reset, high
    input wire logic [4:0] regAddr,                       // register offset
    input wire logic [15:0] regWdata,                     // write data
    input wire logic regWr,                               // write strobe
    input wire logic regRd,                               // read strobe
    output logic [15:0] regRdata,                         // read data, next cycle
    input wire phy_regs_pkg::phy_status_type phyStatus,   // link status inputs
    input wire phy_regs_pkg::idle_err_type idleErr,       // idle error inputs
    output phy_regs_pkg::mmd_req_type mmdReq,             // device access request
    input wire logic [15:0] mmdRdata,                     // device read data
    input wire logic [SYMBOL_WIDTH-1:0] rxSymbol,         // symbol from line
    input wire logic [SYMBOL_WIDTH-1:0] fabricSymbol,     // symbol from fabric
    output logic [SYMBOL_WIDTH-1:0] txSymbol,             // symbol to line
    output logic loopbackActive,                          // loopback engaged
    output logic irq                                      // interrupt level
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [15:0] setup_ff;
    logic [15:0] index_ff;
    logic [15:0] nxt_index;
    logic [15:0] loop_ff;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [phy_regs_pkg::IRQ_COUNT-1:0] mask_ff;
    logic [phy_regs_pkg::IRQ_COUNT-1:0] irqStatus;
    logic [phy_regs_pkg::IRQ_COUNT-1:0] irqEvent;
    logic [phy_regs_pkg::IRQ_COUNT-1:0] irqClear;
    logic [SYMBOL_WIDTH-1:0] tx_ff;
    logic [phy_regs_pkg::IDLE_COUNT_WIDTH-1:0] idleCount;
    logic idleAtMax;
    logic idleInc;
    logic faultFlag;
    logic gigRead;
    logic winAccess;
    logic winRead;
    logic winWrite;
    logic [4:0] mmdDev;
    phy_regs_pkg::mmd_mode_type mode;

    assign mode = phy_regs_pkg::mmd_mode_type'(
        setup_ff[phy_regs_pkg::SETUP_MODE_MSB:phy_regs_pkg::SETUP_MODE_LSB]);
    assign mmdDev = setup_ff[phy_regs_pkg::SETUP_DEV_MSB:0];
    assign gigRead = regRd && (regAddr == phy_regs_pkg::OFS_GIG_STATUS);
    assign winAccess = (regAddr == phy_regs_pkg::OFS_MMD_DATA);
    assign winRead = regRd && winAccess;
    assign winWrite = regWr && winAccess;

    // ----------------------------------------------------------------
    // gigabit status: latched fault and idle error counter
    // ----------------------------------------------------------------
    sticky_flag u_fault (
        .clock(clock),
        .rst(rst),
        .set(phyStatus.msFault),
        .clr(gigRead),
        .q(faultFlag)
    );

    // count qualifies only while receiving idles in send_n mode
    assign idleInc = idleErr.symbolTick && idleErr.rxIdle && idleErr.txSendN
        && idleErr.rxError;

    sat_counter #(
        .WIDTH(phy_regs_pkg::IDLE_COUNT_WIDTH)
    ) u_idle (
        .clock(clock),
        .rst(rst),
        .inc(idleInc),
        .clr(gigRead),
        .count(idleCount),
        .atMax(idleAtMax)
    );

    // ----------------------------------------------------------------
    // indirect device access
    // ----------------------------------------------------------------

    // setup register holds mode, reserved bits and device number
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            setup_ff <= phy_regs_pkg::SETUP_RESET;
        end else if (regWr && regAddr == phy_regs_pkg::OFS_MMD_SETUP) begin
            setup_ff <= regWdata;
        end
    end

    // index update: direct write in index mode, post increment in the two increment modes
    always_comb begin
        nxt_index = index_ff;
        case (mode)
            phy_regs_pkg::MODE_INDEX: begin
                if (winWrite) begin
                    nxt_index = regWdata;
                end
            end
            phy_regs_pkg::MODE_DATA: begin
                nxt_index = index_ff;
            end
            phy_regs_pkg::MODE_DATA_INC_RW: begin
                if (winWrite || winRead) begin
                    nxt_index = index_ff + phy_regs_pkg::INDEX_STEP;
                end
            end
            phy_regs_pkg::MODE_DATA_INC_WR: begin
                if (winWrite) begin
                    nxt_index = index_ff + phy_regs_pkg::INDEX_STEP;
                end
            end
            default: begin
                nxt_index = index_ff;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_ff <= phy_regs_pkg::DATA_RESET;
        end else begin
            index_ff <= nxt_index;
        end
    end

    // data modes hand the access through to the selected device
    always_comb begin
        mmdReq.rd = winRead && (mode != phy_regs_pkg::MODE_INDEX);
        mmdReq.wr = winWrite && (mode != phy_regs_pkg::MODE_INDEX);
        mmdReq.dev = mmdDev;
        mmdReq.index = index_ff;
        mmdReq.wdata = regWdata;
    end

    // ----------------------------------------------------------------
    // remote loopback
    // ----------------------------------------------------------------

    // loopback register, bit 1 clears on read, bit 0 reads zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loop_ff <= phy_regs_pkg::LOOP_RESET;
        end else if (regWr && regAddr == phy_regs_pkg::OFS_LOOPBACK) begin
            loop_ff <= {regWdata[15:1], 1'b0};
        end else if (regRd && regAddr == phy_regs_pkg::OFS_LOOPBACK) begin
            loop_ff[phy_regs_pkg::LOOP_RC_BIT] <= 1'b0;
        end
    end

    assign loopbackActive = loop_ff[phy_regs_pkg::LOOP_ENABLE_BIT];

    // transmit path picks line receive data or the fabric
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_ff <= '0;
        end else if (loopbackActive) begin
            tx_ff <= rxSymbol;
        end else begin
            tx_ff <= fabricSymbol;
        end
    end

    assign txSymbol = tx_ff;

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    assign irqEvent[phy_regs_pkg::IRQ_FAULT] = phyStatus.msFault;
    assign irqEvent[phy_regs_pkg::IRQ_IDLE_ERR] = idleInc;
    assign irqEvent[phy_regs_pkg::IRQ_SATURATE] = idleInc && idleAtMax;
    assign irqClear = (regWr && regAddr == phy_regs_pkg::OFS_IRQ_STATUS) ?
        regWdata[phy_regs_pkg::IRQ_COUNT-1:0] : '0;

    for (genvar i = 0; i < phy_regs_pkg::IRQ_COUNT; i++) begin : g_irq
        sticky_flag u_flag (
            .clock(clock),
            .rst(rst),
            .set(irqEvent[i]),
            .clr(irqClear[i]),
            .q(irqStatus[i])
        );
    end

    // interrupt mask register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_ff <= phy_regs_pkg::IRQ_MASK_RESET;
        end else if (regWr && regAddr == phy_regs_pkg::OFS_IRQ_MASK) begin
            mask_ff <= regWdata[phy_regs_pkg::IRQ_COUNT-1:0];
        end
    end

    assign irq = |(irqStatus & mask_ff);

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------

    // read mux, unmapped offsets return zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (regRd) begin
            case (regAddr)
                phy_regs_pkg::OFS_GIG_STATUS: begin
                    nxt_rdata[phy_regs_pkg::GIG_FAULT_BIT] = faultFlag;
                    nxt_rdata[phy_regs_pkg::GIG_MASTER_BIT] = phyStatus.msMaster;
                    nxt_rdata[phy_regs_pkg::GIG_LOCAL_BIT] = phyStatus.localRxOk;
                    nxt_rdata[phy_regs_pkg::GIG_REMOTE_BIT] = phyStatus.remoteRxOk;
                    nxt_rdata[phy_regs_pkg::GIG_LP_FULL_BIT] = phyStatus.lpFull;
                    nxt_rdata[phy_regs_pkg::GIG_LP_HALF_BIT] = phyStatus.lpHalf;
                    nxt_rdata[phy_regs_pkg::IDLE_COUNT_WIDTH-1:0] = idleCount;
                end
                phy_regs_pkg::OFS_MMD_SETUP: begin
                    nxt_rdata = setup_ff;
                end
                phy_regs_pkg::OFS_MMD_DATA: begin
                    nxt_rdata = (mode == phy_regs_pkg::MODE_INDEX) ? index_ff : mmdRdata;
                end
                phy_regs_pkg::OFS_EXT_STATUS: begin
                    nxt_rdata = phy_regs_pkg::EXT_STATUS_VALUE;
                end
                phy_regs_pkg::OFS_LOOPBACK: begin
                    nxt_rdata = loop_ff;
                end
                phy_regs_pkg::OFS_IRQ_STATUS: begin
                    nxt_rdata[phy_regs_pkg::IRQ_COUNT-1:0] = irqStatus;
                end
                phy_regs_pkg::OFS_IRQ_MASK: begin
                    nxt_rdata[phy_regs_pkg::IRQ_COUNT-1:0] = mask_ff;
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    // read data stand one cycle, zero otherwise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign regRdata = rdata_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence faultReadSeq;
        gigRead && faultFlag && !phyStatus.msFault;
    endsequence

    sequence faultSeenSeq;
        regRdata[phy_regs_pkg::GIG_FAULT_BIT] && !faultFlag;
    endsequence

    AST_FAULT_READ: assert property (@(posedge clock) disable iff (rst)
        faultReadSeq |=> faultSeenSeq) else $error("fault not reported then cleared");

    AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (rst)
        (phyStatus.msFault ##1 !gigRead [*3]) |=> faultFlag)
        else $error("fault bit dropped without read");

    AST_RESOLUTION: assert property (@(posedge clock) disable iff (rst)
        gigRead |=> regRdata[phy_regs_pkg::GIG_MASTER_BIT] == $past(phyStatus.msMaster))
        else $error("master resolution wrong");

    AST_RECEIVERS: assert property (@(posedge clock) disable iff (rst)
        gigRead |=> regRdata[13:12] == $past({phyStatus.localRxOk, phyStatus.remoteRxOk}))
        else $error("receiver status wrong");

    AST_PARTNER_CAP: assert property (@(posedge clock) disable iff (rst)
        gigRead |=> regRdata[11:10] == $past({phyStatus.lpFull, phyStatus.lpHalf}))
        else $error("partner capability wrong");

    AST_IDLE_INC: assert property (@(posedge clock) disable iff (rst)
        (idleInc && !gigRead && !idleAtMax) |=> idleCount == $past(idleCount) + 8'h01)
        else $error("idle count did not advance");

    AST_IDLE_STILL: assert property (@(posedge clock) disable iff (rst)
        (!idleErr.txSendN && !gigRead) |=> $stable(idleCount))
        else $error("idle count moved outside send_n");

    AST_READ_CLEARS: assert property (@(posedge clock) disable iff (rst)
        (gigRead && !idleInc) ##1 (!idleInc && !gigRead) |=> idleCount == 8'h00)
        else $error("idle count kept after read");

    AST_INDEX_WRITE: assert property (@(posedge clock) disable iff (rst)
        (winWrite && mode == phy_regs_pkg::MODE_INDEX) |=> index_ff == $past(regWdata))
        else $error("index not written");

    AST_POST_INC: assert property (@(posedge clock) disable iff (rst)
        (winRead && mode == phy_regs_pkg::MODE_DATA_INC_WR) |=> $stable(index_ff))
        else $error("index moved on read in write-only increment");

    AST_INC_WRITE: assert property (@(posedge clock) disable iff (rst)
        (winWrite && setup_ff[15]) |=> index_ff == $past(index_ff) + 16'h0001)
        else $error("index not incremented");

    AST_WINDOW_DEV: assert property (@(posedge clock) disable iff (rst)
        (mmdReq.rd || mmdReq.wr) |-> mmdReq.dev == setup_ff[4:0])
        else $error("access aimed at wrong device");

    AST_DATA_READ: assert property (@(posedge clock) disable iff (rst)
        mmdReq.rd |=> regRdata == $past(mmdRdata))
        else $error("device data not returned");

    AST_EXT_FIXED: assert property (@(posedge clock) disable iff (rst)
        (regRd && regAddr == phy_regs_pkg::OFS_EXT_STATUS) |=> regRdata[15:12] == 4'h3)
        else $error("extended status bits wrong");

    AST_LOOPBACK: assert property (@(posedge clock) disable iff (rst)
        loopbackActive |=> txSymbol == $past(rxSymbol))
        else $error("loopback did not return line data");

    AST_NORMAL_PATH: assert property (@(posedge clock) disable iff (rst)
        !loopbackActive |=> txSymbol == $past(fabricSymbol))
        else $error("fabric data not transmitted");

endmodule

// ---- src/phy_regs_pkg.sv ----
package phy_regs_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_GIG_STATUS = 5'h0A;
    localparam logic [4:0] OFS_MMD_SETUP = 5'h0D;
    localparam logic [4:0] OFS_MMD_DATA = 5'h0E;
    localparam logic [4:0] OFS_EXT_STATUS = 5'h0F;
    localparam logic [4:0] OFS_LOOPBACK = 5'h11;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h1C;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h1D;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int GIG_FAULT_BIT = 15;
    localparam int GIG_MASTER_BIT = 14;
    localparam int GIG_LOCAL_BIT = 13;
    localparam int GIG_REMOTE_BIT = 12;
    localparam int GIG_LP_FULL_BIT = 11;
    localparam int GIG_LP_HALF_BIT = 10;
    localparam int IDLE_COUNT_WIDTH = 8;
    localparam int SETUP_MODE_MSB = 15;
    localparam int SETUP_MODE_LSB = 14;
    localparam int SETUP_DEV_MSB = 4;
    localparam int LOOP_ENABLE_BIT = 8;
    localparam int LOOP_RC_BIT = 1;
    localparam int LOOP_RO_BIT = 0;

    // ----------------------------------------------------------------
    // reset and fixed values
    // ----------------------------------------------------------------
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] LOOP_RESET = 16'h00F4;
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h3000;
    localparam logic [15:0] INDEX_STEP = 16'h0001;

    // ----------------------------------------------------------------
    // interrupt events
    // ----------------------------------------------------------------
    localparam int IRQ_COUNT = 3;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_IDLE_ERR = 1;
    localparam int IRQ_SATURATE = 2;
    localparam logic [IRQ_COUNT-1:0] IRQ_MASK_RESET = 3'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_INDEX = 2'b00,
        MODE_DATA = 2'b01,
        MODE_DATA_INC_RW = 2'b10,
        MODE_DATA_INC_WR = 2'b11
    } mmd_mode_type;

    typedef struct packed {
        logic msFault;     // fault detect pulse
        logic msMaster;    // resolved to master
        logic localRxOk;   // local receiver ok
        logic remoteRxOk;  // remote receiver ok
        logic lpFull;      // partner gigabit full duplex
        logic lpHalf;      // partner gigabit half duplex
    } phy_status_type;

    typedef struct packed {
        logic symbolTick;  // one symbol period
        logic rxIdle;      // receiving idles
        logic txSendN;     // transmit mode is send_n
        logic rxError;     // receive error status is error
    } idle_err_type;

    typedef struct packed {
        logic rd;              // window read
        logic wr;              // window write
        logic [4:0] dev;       // target device
        logic [15:0] index;    // register index in device
        logic [15:0] wdata;    // write value
    } mmd_req_type;

endpackage

// ---- src/sticky_flag.sv ----
module sticky_flag (
    input wire logic clock,  // system clock
    input wire logic rst,    // async reset, high
    input wire logic set,    // event
    input wire logic clr,    // clear request
    output logic q           // flag
);

    // ----------------------------------------------------------------
    // flag with set winning over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

    AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
        set |=> q) else $error("event lost against clear");

    AST_CLR_TAKES: assert property (@(posedge clock) disable iff (rst)
        (clr && !set) |=> !q) else $error("flag did not clear");

endmodule

// ---- src/sat_counter.sv ----
module sat_counter #(
    parameter int WIDTH = 8  // counter width
) (
    input wire logic clock,          // system clock
    input wire logic rst,            // async reset, high
    input wire logic inc,            // count one
    input wire logic clr,            // clear request
    output logic [WIDTH-1:0] count,  // current count
    output logic atMax               // count is full
);

    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    assign atMax = &count;

    // ----------------------------------------------------------------
    // saturating count, clear with same-cycle event keeps the event
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (clr) begin
            count <= inc ? ONE : '0;
        end else if (inc && !atMax) begin
            count <= count + ONE;
        end
    end

    AST_SATURATE: assert property (@(posedge clock) disable iff (rst)
        (atMax && !clr) |=> atMax) else $error("counter wrapped");

    AST_CLEAR_ZERO: assert property (@(posedge clock) disable iff (rst)
        (clr && !inc) |=> (count == '0)) else $error("counter not cleared");

endmodule

// ---- tb/mmd_device_model.sv ----
module mmd_device_model (
    input wire logic clock,                        // system clock
    input wire phy_regs_pkg::mmd_req_type mmdReq,  // access request
    output logic [15:0] mmdRdata                   // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [64];
    logic [15:0] junk = 16'hA5C3;
    // storage per device and index, junk toggles every clock and is returned while not read
    always @(posedge clock) begin
        junk <= ~junk;
        if (mmdReq.wr) begin
            mem[{mmdReq.dev[1:0], mmdReq.index[3:0]}] <= mmdReq.wdata;
        end
    end
    // read data only while a read is requested
    assign mmdRdata = mmdReq.rd ? mem[{mmdReq.dev[1:0], mmdReq.index[3:0]}] : junk;
endmodule

// ---- tb/tb_phy_gig_status_mmd_loopback_regs.sv ----
module tb_phy_gig_status_mmd_loopback_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // register offsets used by the scenarios
    localparam logic [4:0] OFS_GIG_STATUS = phy_regs_pkg::OFS_GIG_STATUS;
    localparam logic [4:0] OFS_MMD_SETUP = phy_regs_pkg::OFS_MMD_SETUP;
    localparam logic [4:0] OFS_MMD_DATA = phy_regs_pkg::OFS_MMD_DATA;
    localparam logic [4:0] OFS_EXT_STATUS = phy_regs_pkg::OFS_EXT_STATUS;
    localparam logic [4:0] OFS_LOOPBACK = phy_regs_pkg::OFS_LOOPBACK;
    localparam logic [4:0] OFS_IRQ_STATUS = phy_regs_pkg::OFS_IRQ_STATUS;
    localparam logic [4:0] OFS_IRQ_MASK = phy_regs_pkg::OFS_IRQ_MASK;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic clock, rst, regWr, regRd, loopbackActive, irq, rdLate;
    logic [4:0] regAddr;
    logic [15:0] regWdata, regRdata, mmdRdata, gig, expV, a, b, c;
    logic [7:0] rxSymbol, fabricSymbol, txSymbol;
    phy_regs_pkg::phy_status_type phyStatus;
    phy_regs_pkg::idle_err_type idleErr;
    phy_regs_pkg::mmd_req_type mmdReq;
    logic [15:0] expQ [$];
    int checked, fail_count, n;
    phy_gig_status_mmd_loopback_regs dut (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .phyStatus(phyStatus), .idleErr(idleErr), .mmdReq(mmdReq), .mmdRdata(mmdRdata),
        .rxSymbol(rxSymbol), .fabricSymbol(fabricSymbol), .txSymbol(txSymbol),
        .loopbackActive(loopbackActive), .irq(irq));
    mmd_device_model partner (.clock(clock), .mmdReq(mmdReq), .mmdRdata(mmdRdata));
    // ------------------------------------------------------------
    // clock, bus tasks, read monitor
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic wr(input logic [4:0] ad, input logic [15:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] ad, input logic [15:0] e);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= ad;
        expQ.push_back(e);
        @(posedge clock);
        regRd <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read data stand in the cycle after the strobe
    always @(posedge clock) begin
        rdLate <= regRd;
        if (rdLate === 1'b1) begin
            expV = expQ.pop_front();
            `CHK(regRdata, expV)
        end
    end
    // watchdog
    initial begin
        #100000;
        fail_count++;
        results();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {regWr, regRd, regAddr, regWdata, phyStatus, idleErr} = '0;
        {rxSymbol, fabricSymbol, checked, fail_count} = '0;
        rst = 1'b1;
        void'($urandom(59970));
        {a, b, c} = 48'({$urandom, $urandom});
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_MMD_SETUP, 16'h0000);
        rd(OFS_MMD_DATA, 16'h0000);
        rd(OFS_LOOPBACK, 16'h00F4);
        wr(OFS_EXT_STATUS, 16'hFFFF);
        rd(OFS_EXT_STATUS, 16'h3000);
        wr(5'h05, 16'hFFFF);
        rd(5'h05, 16'h0000);
        $display("test reset values done");
        for (n = 0; n < 4; n++) begin
            gig = {1'b0, 5'($urandom), 10'h000};
            phyStatus <= gig[15:10];
            rd(OFS_GIG_STATUS, gig);
        end
        phyStatus.msFault <= 1'b1;
        @(posedge clock);
        phyStatus.msFault <= 1'b0;
        // let the latched fault sit unread for a few cycles
        repeat (4) @(posedge clock);
        rd(OFS_GIG_STATUS, gig | 16'h8000);
        rd(OFS_GIG_STATUS, gig);
        @(negedge clock);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 16'h0007);
        @(negedge clock);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_STATUS, 16'h0001);
        @(negedge clock);
        `CHK(irq, 1'b0)
        $display("test status and fault done");
        n = 1 + $urandom % 20;
        @(posedge clock);
        idleErr <= 4'hF;
        repeat (n) @(posedge clock);
        idleErr <= 4'hB;
        @(posedge clock);
        idleErr <= 4'hD;
        @(posedge clock);
        idleErr <= 4'h0;
        rd(OFS_GIG_STATUS, gig | 16'(n));
        rd(OFS_GIG_STATUS, gig);
        idleErr <= 4'hF;
        repeat (300) @(posedge clock);
        idleErr <= 4'h0;
        rd(OFS_GIG_STATUS, gig | 16'h00FF);
        rd(OFS_IRQ_STATUS, 16'h0006);
        $display("test idle counter done");
        wr(OFS_MMD_SETUP, 16'h0001);
        wr(OFS_MMD_DATA, 16'h0005);
        wr(OFS_MMD_SETUP, 16'hC001);
        wr(OFS_MMD_DATA, a);
        wr(OFS_MMD_DATA, b);
        wr(OFS_MMD_DATA, c);
        rd(OFS_MMD_SETUP, 16'hC001);
        wr(OFS_MMD_SETUP, 16'h0001);
        rd(OFS_MMD_DATA, 16'h0008);
        wr(OFS_MMD_DATA, 16'h0005);
        wr(OFS_MMD_SETUP, 16'h8001);
        rd(OFS_MMD_DATA, a);
        rd(OFS_MMD_DATA, b);
        wr(OFS_MMD_SETUP, 16'h4002);
        wr(OFS_MMD_DATA, ~c);
        wr(OFS_MMD_SETUP, 16'h4001);
        rd(OFS_MMD_DATA, c);
        rd(OFS_MMD_DATA, c);
        wr(OFS_MMD_SETUP, 16'hC001);
        rd(OFS_MMD_DATA, c);
        wr(OFS_MMD_SETUP, 16'h0001);
        rd(OFS_MMD_DATA, 16'h0007);
        $display("test indirect window done");
        rxSymbol <= a[7:0];
        fabricSymbol <= ~a[7:0];
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHK(txSymbol, ~a[7:0])
        wr(OFS_LOOPBACK, 16'h01F7);
        rd(OFS_LOOPBACK, 16'h01F6);
        rd(OFS_LOOPBACK, 16'h01F4);
        @(negedge clock);
        `CHK(loopbackActive, 1'b1)
        `CHK(txSymbol, a[7:0])
        wr(OFS_LOOPBACK, 16'h00F4);
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHK(txSymbol, ~a[7:0])
        `CHK(loopbackActive, 1'b0)
        $display("test loopback done");
        repeat (3) @(posedge clock);
        `CHK(expQ.size(), 0)
        results();
    end
endmodule
